// ===== shared/link_regs.svh
// register indexes, field positions, reset values and character codes
// assumes an 8-bit register word placed in the low bits of a 32-bit bus word
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

// ==========================================================
// register indexes (byte address is four times the index)
`define IDX_LINK_BLOCK_ENABLE 12'h200
`define IDX_TEST_PATTERN_SELECT 12'h205
`define IDX_LINK_IDENTIFIER 12'h206
`define IDX_FRAME_END_CHAR_SELECT 12'h207
`define IDX_LINK_STATUS_WORD 12'h208
`define IDX_IRQ_MASK 12'h210

// ==========================================================
// field positions of the status word
`define ST_LINK_UP 6
`define ST_SYNC 5
`define ST_REALIGNED 4
`define ST_PHASE_SET 3
`define ST_PLL_LOCKED 2

// ==========================================================
// reset values
`define RST_ENABLE 1'h1
`define RST_TEST_SEL 4'h0
`define RST_IDENT 8'h00
`define RST_FRAME_END_CHAR_SELECT 2'h0
`define RST_STATUS 8'h00
`define RST_MASK 8'h00
`define RST_PRBS_SEED 23'h7fffff

// ==========================================================
// 8b/10b character codes (unencoded byte values)
`define CHR_K28_7 8'hfc
`define CHR_K28_1 8'h3c
`define CHR_K28_5 8'hbc
`define CHR_D21_5 8'hb5
`define CHR_LOW 8'h00
`define CHR_HIGH 8'hff

`endif

// ===== shared/link_pkg.sv
// types shared by the link test and status register block
// assumes nothing of its surroundings
package link_pkg;

    // ==========================================================
    // test pattern selections
    typedef enum logic [3:0] {
        TM_NORMAL = 4'b0000,
        TM_PRBS7 = 4'b0001,
        TM_PRBS15 = 4'b0010,
        TM_PRBS23 = 4'b0011,
        TM_RAMP = 4'b0100,
        TM_TRANSPORT = 4'b0101,
        TM_D21_5 = 4'b0110,
        TM_K28_5 = 4'b0111,
        TM_ILA_REPEAT = 4'b1000,
        TM_RPAT = 4'b1001,
        TM_HOLD_LOW = 4'b1010,
        TM_HOLD_HIGH = 4'b1011
    } test_mode_type;

    // ==========================================================
    // end-of-frame comma selections
    typedef enum logic [1:0] {
        FC_K28_7 = 2'b00,
        FC_K28_1 = 2'b01,
        FC_K28_5 = 2'b10,
        FC_RESERVED = 2'b11
    } frame_char_type;

endpackage : link_pkg

// ===== hw/link_test_status_regs.sv
// link test-pattern, identifier, frame character and status registers
// with a single-lane symbol source, behind an AHB-Lite slave.
// assumes one 100 MHz clock; sync and PLL lock arrive asynchronously,
// all other link inputs come from logic on the same clock.
`timescale 1ns/10ps
`include "link_regs.svh"

module link_test_status_regs #(
    parameter int ADDR_W = 14
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic link_up,
    input wire logic sync_n_pin,
    input wire logic pll_locked_pin,
    input wire logic sysref_event,
    input wire logic sysref_phase_shift,
    input wire logic [7:0] sample_data,
    input wire logic frame_end_ok,
    output logic [7:0] lane_symbol,
    output logic lane_is_k,
    output logic [3:0] lane_test_mode,
    output logic [7:0] link_a_identifier,
    output logic [7:0] link_b_identifier,
    output logic link_reset_b,
    output logic serializer_power_down,
    output logic link_clock_enable,
    output logic irq
);

    // ==========================================================
    // elaboration checks
    if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 14 and 32");
    end

    // shared decode of a word index from a byte address
    function automatic logic [11:0] word_index(input logic [31:0] a);
        word_index = a[13:2];
    endfunction : word_index

    // reserved selections fall back to the K28.7 comma
    function automatic logic [7:0] comma_code(input link_pkg::frame_char_type f);
        case (f)
            link_pkg::FC_K28_1: comma_code = `CHR_K28_1;
            link_pkg::FC_K28_5: comma_code = `CHR_K28_5;
            default: comma_code = `CHR_K28_7;
        endcase
    endfunction : comma_code

    // ==========================================================
    // pin synchronisers
    logic [1:0] sync_n_sync_r;
    logic [1:0] pll_sync_r;
    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_n_sync_r <= 2'h0;
            pll_sync_r <= 2'h0;
        end else begin
            sync_n_sync_r <= {sync_n_sync_r[0], sync_n_pin};
            pll_sync_r <= {pll_sync_r[0], pll_locked_pin};
        end
    end

    // ==========================================================
    // AHB-Lite slave: zero wait states, OKAY always
    logic dph_valid_r;
    logic dph_valid_nxt;
    logic dph_write_r;
    logic dph_write_nxt;
    logic [11:0] dph_index_r;
    logic [11:0] dph_index_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic hreadyout_r;
    logic hresp_r;
    logic addr_take;
    logic wr_en;
    logic [7:0] wr_byte;

    // registers of the block
    logic enable_r;
    logic enable_nxt;
    logic [3:0] test_sel_r;
    logic [3:0] test_sel_nxt;
    logic [7:0] ident_r;
    logic [7:0] ident_nxt;
    logic [1:0] frame_end_char_select_r;
    logic [1:0] frame_end_char_select_nxt;
    logic realigned_r;
    logic realigned_nxt;
    logic phase_set_r;
    logic phase_set_nxt;
    logic first_sysref_done_r;
    logic first_sysref_done_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [7:0] status_word;

    // a transfer is taken only when the previous one has completed
    assign addr_take = hsel && htrans[1] && hready;
    assign wr_en = dph_valid_r && dph_write_r;
    assign wr_byte = hwdata[7:0];

    // live status: reserved bits read zero
    always_comb begin
        status_word = `RST_STATUS;
        status_word[`ST_LINK_UP] = link_up && enable_r;
        status_word[`ST_SYNC] = sync_n_sync_r[1];
        status_word[`ST_REALIGNED] = realigned_r;
        status_word[`ST_PHASE_SET] = phase_set_r;
        status_word[`ST_PLL_LOCKED] = pll_sync_r[1];
    end

    // address phase capture and read data; read data is formed at the
    // address phase so it stands at the start of the data phase
    always_comb begin
        dph_valid_nxt = addr_take;
        dph_write_nxt = hwrite;
        dph_index_nxt = word_index(haddr);
        hrdata_nxt = 32'h0;
        if (addr_take && !hwrite) begin
            case (word_index(haddr))
                `IDX_LINK_BLOCK_ENABLE: hrdata_nxt[0] = enable_r;
                `IDX_TEST_PATTERN_SELECT: hrdata_nxt[3:0] = test_sel_r;
                `IDX_LINK_IDENTIFIER: hrdata_nxt[7:0] = {ident_r[7:1], 1'b0};
                `IDX_FRAME_END_CHAR_SELECT: hrdata_nxt[1:0] = frame_end_char_select_r;
                `IDX_LINK_STATUS_WORD: hrdata_nxt[7:0] = status_word;
                `IDX_IRQ_MASK: hrdata_nxt[7:0] = mask_r;
                default: hrdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dph_valid_r <= 1'b0;
            dph_write_r <= 1'b0;
            dph_index_r <= 12'h0;
            hrdata_r <= 32'h0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            dph_valid_r <= dph_valid_nxt;
            dph_write_r <= dph_write_nxt;
            dph_index_r <= dph_index_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // ==========================================================
    // configuration, sticky flags and interrupt
    // a one written to a flag clears it, but an event in the same
    // cycle wins so that no alignment event goes unseen
    always_comb begin
        enable_nxt = enable_r;
        test_sel_nxt = test_sel_r;
        ident_nxt = ident_r;
        frame_end_char_select_nxt = frame_end_char_select_r;
        mask_nxt = mask_r;
        realigned_nxt = realigned_r;
        phase_set_nxt = phase_set_r;
        first_sysref_done_nxt = first_sysref_done_r;
        if (wr_en) begin
            case (dph_index_r)
                `IDX_LINK_BLOCK_ENABLE: enable_nxt = wr_byte[0];
                // written values take effect freely; software only changes
                // them while the link is disabled
                `IDX_TEST_PATTERN_SELECT: test_sel_nxt = wr_byte[3:0];
                `IDX_LINK_IDENTIFIER: ident_nxt = {wr_byte[7:1], 1'b0};
                `IDX_FRAME_END_CHAR_SELECT: frame_end_char_select_nxt = wr_byte[1:0];
                `IDX_IRQ_MASK: mask_nxt = wr_byte;
                `IDX_LINK_STATUS_WORD: begin
                    if (wr_byte[`ST_REALIGNED]) begin
                        realigned_nxt = 1'b0;
                    end
                    if (wr_byte[`ST_PHASE_SET]) begin
                        phase_set_nxt = 1'b0;
                    end
                end
                default: enable_nxt = enable_r;
            endcase
        end
        // while disabled the multiframe counter ignores SYSREF
        if (!enable_r) begin
            first_sysref_done_nxt = 1'b0;
        end else if (sysref_event) begin
            first_sysref_done_nxt = 1'b1;
            if (!first_sysref_done_r) begin
                phase_set_nxt = 1'b1;
            end
        end
        if (enable_r && sysref_phase_shift) begin
            realigned_nxt = 1'b1;
        end
        irq_nxt = |(status_word & mask_r &
            (8'h1 << `ST_REALIGNED | 8'h1 << `ST_PHASE_SET));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_r <= `RST_ENABLE;
            test_sel_r <= `RST_TEST_SEL;
            ident_r <= `RST_IDENT;
            frame_end_char_select_r <= `RST_FRAME_END_CHAR_SELECT;
            mask_r <= `RST_MASK;
            realigned_r <= 1'b0;
            phase_set_r <= 1'b0;
            first_sysref_done_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            test_sel_r <= test_sel_nxt;
            ident_r <= ident_nxt;
            frame_end_char_select_r <= frame_end_char_select_nxt;
            mask_r <= mask_nxt;
            realigned_r <= realigned_nxt;
            phase_set_r <= phase_set_nxt;
            first_sysref_done_r <= first_sysref_done_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ==========================================================
    // lane symbol source
    logic [22:0] prbs_r;
    logic [22:0] prbs_nxt;
    logic [7:0] ramp_r;
    logic [7:0] ramp_nxt;
    logic [7:0] sym_r;
    logic [7:0] sym_nxt;
    logic k_r;
    logic k_nxt;
    logic [3:0] mode_r;
    logic [3:0] mode_nxt;
    logic [7:0] ida_r;
    logic [7:0] ida_nxt;
    logic [7:0] idb_r;
    logic [7:0] idb_nxt;
    logic link_rst_b_r;
    logic pwr_down_r;
    logic clk_en_r;
    logic prbs_fb;
    link_pkg::test_mode_type tmode;

    assign tmode = link_pkg::test_mode_type'(test_sel_r);

    // one shared register serves all three sequences; only the taps move
    always_comb begin
        case (tmode)
            link_pkg::TM_PRBS7: prbs_fb = prbs_r[6] ^ prbs_r[5];
            link_pkg::TM_PRBS15: prbs_fb = prbs_r[14] ^ prbs_r[13];
            default: prbs_fb = prbs_r[22] ^ prbs_r[17];
        endcase
    end

    always_comb begin
        prbs_nxt = {prbs_r[21:0], prbs_fb};
        ramp_nxt = ramp_r + 8'h01;
        sym_nxt = sample_data;
        k_nxt = 1'b0;
        mode_nxt = test_sel_r;
        // identifiers for the alignment configuration data
        ida_nxt = {ident_r[7:1], 1'b0};
        idb_nxt = {ident_r[7:1], 1'b0} + 8'h01;
        case (tmode)
            link_pkg::TM_NORMAL: begin
                if (frame_end_ok) begin
                    sym_nxt = comma_code(link_pkg::frame_char_type'(frame_end_char_select_r));
                    k_nxt = 1'b1;
                end
            end
            link_pkg::TM_PRBS7, link_pkg::TM_PRBS15, link_pkg::TM_PRBS23:
                sym_nxt = prbs_r[7:0];
            link_pkg::TM_RAMP: sym_nxt = ramp_r;
            // transport, alignment repeat and RPAT content is built by the
            // lane framer from lane_test_mode; samples stand meanwhile
            link_pkg::TM_TRANSPORT: sym_nxt = sample_data;
            link_pkg::TM_D21_5: sym_nxt = `CHR_D21_5;
            link_pkg::TM_K28_5: begin
                sym_nxt = `CHR_K28_5;
                k_nxt = 1'b1;
            end
            link_pkg::TM_ILA_REPEAT: sym_nxt = sample_data;
            link_pkg::TM_RPAT: sym_nxt = sample_data;
            link_pkg::TM_HOLD_LOW: sym_nxt = `CHR_LOW;
            link_pkg::TM_HOLD_HIGH: sym_nxt = `CHR_HIGH;
            // reserved selections send nothing but zeros
            default: begin
                sym_nxt = `CHR_LOW;
                mode_nxt = 4'h0;
            end
        endcase
        // disabled: sequences, ramp and lane symbol held at their reset state; mode and identifiers still follow
        if (!enable_r) begin
            prbs_nxt = `RST_PRBS_SEED;
            ramp_nxt = 8'h00;
            sym_nxt = `CHR_LOW;
            k_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prbs_r <= `RST_PRBS_SEED;
            ramp_r <= 8'h00;
            sym_r <= `CHR_LOW;
            k_r <= 1'b0;
            mode_r <= 4'h0;
            ida_r <= `RST_IDENT;
            idb_r <= 8'h01;
            link_rst_b_r <= 1'b0;
            pwr_down_r <= 1'b1;
            clk_en_r <= 1'b0;
        end else begin
            prbs_r <= prbs_nxt;
            ramp_r <= ramp_nxt;
            sym_r <= sym_nxt;
            k_r <= k_nxt;
            mode_r <= mode_nxt;
            ida_r <= ida_nxt;
            idb_r <= idb_nxt;
            link_rst_b_r <= enable_r;
            pwr_down_r <= !enable_r;
            clk_en_r <= enable_r;
        end
    end

    // ==========================================================
    // outputs, all straight from flip-flops
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign lane_symbol = sym_r;
    assign lane_is_k = k_r;
    assign lane_test_mode = mode_r;
    assign link_a_identifier = ida_r;
    assign link_b_identifier = idb_r;
    assign link_reset_b = link_rst_b_r;
    assign serializer_power_down = pwr_down_r;
    assign link_clock_enable = clk_en_r;
    assign irq = irq_r;

endmodule : link_test_status_regs

// ===== tb/link_test_status_regs_properties.sv
// checker of the link register block, watching only its top ports
// assumes one clock domain and the active-low asynchronous reset rst_b
`timescale 1ns/10ps
module link_test_status_regs_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic frame_end_ok,
    input wire logic [7:0] lane_symbol,
    input wire logic lane_is_k,
    input wire logic [3:0] lane_test_mode,
    input wire logic [7:0] link_a_identifier,
    input wire logic [7:0] link_b_identifier,
    input wire logic link_reset_b,
    input wire logic serializer_power_down,
    input wire logic link_clock_enable
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // bus and identifiers
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_id_pair_plus: assert property (link_b_identifier == link_a_identifier + 8'h01)
        else $error("second link identifier is not first plus one");
    a_id_even_only: assert property (link_a_identifier[0] == 1'b0)
        else $error("identifier low bit not zero");

    // ==========================================================
    // lane content; two settled cycles so mode changes never race
    a_k28_5_repeat: assert property (
        (link_reset_b && lane_test_mode == 4'h7) [*2] |-> lane_symbol == 8'hbc && lane_is_k)
        else $error("k28.5 mode not sending k28.5");
    a_hold_levels: assert property (
        (link_reset_b && (lane_test_mode == 4'ha || lane_test_mode == 4'hb)) [*2]
        |-> lane_symbol == {8{lane_test_mode[0]}})
        else $error("held lane level wrong");
    a_mode_in_range: assert property (lane_test_mode <= 4'hb)
        else $error("reserved test mode reported");
    a_comma_on_end: assert property (
        (lane_test_mode == 4'h0 && frame_end_ok && link_reset_b && link_clock_enable)
        ##1 (link_reset_b && link_clock_enable) |-> lane_is_k)
        else $error("no comma after allowed frame end");

    // ==========================================================
    // enable side effects
    a_power_follows: assert property (serializer_power_down == !link_clock_enable)
        else $error("serializer power not tied to enable");
    a_reset_follows: assert property (
        $changed(link_clock_enable) |-> ##[0:2] (link_reset_b == link_clock_enable))
        else $error("link reset does not follow enable");
    a_lane_quiet: assert property (
        (!link_clock_enable) [*2] |-> lane_symbol == 8'h00 && !lane_is_k)
        else $error("lane not quiet while disabled");
endmodule : link_test_status_regs_properties

bind link_test_status_regs link_test_status_regs_properties u_props (
    .clk(clk),
    .rst_b(rst_b),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .frame_end_ok(frame_end_ok),
    .lane_symbol(lane_symbol),
    .lane_is_k(lane_is_k),
    .lane_test_mode(lane_test_mode),
    .link_a_identifier(link_a_identifier),
    .link_b_identifier(link_b_identifier),
    .link_reset_b(link_reset_b),
    .serializer_power_down(serializer_power_down),
    .link_clock_enable(link_clock_enable)
);

// ===== tb/link_rx_model.sv
// receiver stand-in: requests sync until three k28.5 symbols and then any fourth k symbol arrive in a row
// assumes unencoded lane bytes, one per clock, on the block's clock
`timescale 1ns/10ps
module link_rx_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] lane_symbol,
    input wire logic lane_is_k,
    input wire logic link_clock_enable,
    output logic sync_req_b,
    output logic link_up
);
    logic [2:0] k_count_r;

    // ==========================================================
    // code group sync; a disabled link always goes back to requesting
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            k_count_r <= 3'h0;
            sync_req_b <= 1'b0;
            link_up <= 1'b0;
        end else if (!link_clock_enable) begin
            k_count_r <= 3'h0;
            sync_req_b <= 1'b0;
            link_up <= 1'b0;
        end else if (!sync_req_b) begin
            k_count_r <= (lane_is_k && lane_symbol == 8'hbc) ? k_count_r + 3'h1 : 3'h0;
            sync_req_b <= (k_count_r == 3'h3) && lane_is_k;
        end else begin
            link_up <= 1'b1;
        end
    end
endmodule : link_rx_model

// ===== tb/tb_serial_link_test_and_status_regs.sv
// self-checking bench of the link register block with a receiver stand-in
// assumes the design, its package header and the checker bind are compiled first
`timescale 1ns/10ps
`include "link_regs.svh"
module tb_serial_link_test_and_status_regs;
    typedef struct {logic [11:0] idx; logic [31:0] wd; logic [31:0] exp;} row_type;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, link_up, sync_n_pin, pll_locked_pin;
    logic sysref_event, sysref_phase_shift, frame_end_ok, lane_is_k, link_reset_b, irq;
    logic serializer_power_down, link_clock_enable;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] lane_test_mode;
    logic [7:0] sample_data, lane_symbol, link_a_identifier, link_b_identifier, s;
    logic [7:0] commas [4] = '{`CHR_K28_7, `CHR_K28_1, `CHR_K28_5, `CHR_K28_7};
    logic [7:0] syms [16] = '{8'h5a, 8'h0, 8'h0, 8'h0, 8'h0, 8'h5a, 8'hb5, 8'hbc,
        8'h5a, 8'h5a, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    row_type rows [5] = '{'{12'h206, 32'h55, 32'h54}, '{12'h207, 32'h01, 32'h01},
        '{12'h205, 32'h0b, 32'h0b}, '{12'h3ff, 32'hff, 32'h00}, '{12'h206, 32'ha6, 32'ha6}};
    int mismatches = 0;
    int compares = 0;

    link_test_status_regs u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_up(link_up), .sync_n_pin(sync_n_pin), .pll_locked_pin(pll_locked_pin),
        .sysref_event(sysref_event), .sysref_phase_shift(sysref_phase_shift),
        .sample_data(sample_data), .frame_end_ok(frame_end_ok), .lane_symbol(lane_symbol),
        .lane_is_k(lane_is_k), .lane_test_mode(lane_test_mode),
        .link_a_identifier(link_a_identifier), .link_b_identifier(link_b_identifier),
        .link_reset_b(link_reset_b), .serializer_power_down(serializer_power_down),
        .link_clock_enable(link_clock_enable), .irq(irq));
    link_rx_model u_rx (.clk(clk), .rst_b(rst_b), .lane_symbol(lane_symbol),
        .lane_is_k(lane_is_k), .link_clock_enable(link_clock_enable),
        .sync_req_b(sync_n_pin), .link_up(link_up));

    // ==========================================================
    // verdict and comparison
    task tally_and_finish;
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one single transfer; ev pulses a phase-shift event during the data phase
    task bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd, input logic ev);
        haddr <= {18'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        sysref_phase_shift <= ev;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        sysref_phase_shift <= 1'b0;
    endtask : bus

    // settings only change while the link is disabled, then it is enabled again
    task set_mode(input logic [11:0] idx, input logic [31:0] v);
        @(posedge clk);
        bus(1'b1, `IDX_LINK_BLOCK_ENABLE, 32'h0, 1'b0);
        bus(1'b1, idx, v, 1'b0);
        bus(1'b1, `IDX_LINK_BLOCK_ENABLE, 32'h1, 1'b0);
        repeat (4) @(posedge clk);
    endtask : set_mode

    task sysref_pulse;
        @(posedge clk);
        sysref_event <= 1'b1;
        @(posedge clk);
        sysref_event <= 1'b0;
    endtask : sysref_pulse

    // ==========================================================
    // clock and watchdog; the whole run needs well under 2000 cycles
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        hsel = 1'b1;
        hsize = 3'h2;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pll_locked_pin = 1'b0;
        sysref_event = 1'b0;
        sysref_phase_shift = 1'b0;
        sample_data = 8'h5a;
        frame_end_ok = 1'b0;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(32'(link_b_identifier), 32'h01);
        bus(1'b0, `IDX_LINK_BLOCK_ENABLE, 32'h0, 1'b0);
        chk(rd, 32'h1);
        bus(1'b1, `IDX_LINK_BLOCK_ENABLE, 32'h0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, rows[i].idx, rows[i].wd, 1'b0);
            bus(1'b0, rows[i].idx, 32'h0, 1'b0);
            chk(rd, rows[i].exp);
        end
        chk(32'({link_b_identifier, link_a_identifier}), 32'ha7a6);
        // every test select code, reserved ones included
        for (int m = 0; m < 16; m++) begin
            set_mode(`IDX_TEST_PATTERN_SELECT, 32'(m));
            #1;
            chk(32'(lane_test_mode), (m > 11) ? 32'h0 : 32'(m));
            if (m >= 1 && m <= 4) begin
                s = lane_symbol;
                @(posedge clk);
                #1;
                // each lfsr step moves the low byte up by one; the ramp counts
                if (m == 4) chk(32'(lane_symbol), 32'(s + 8'h01));
                else chk(32'(lane_symbol[7:1]), 32'(s[6:0]));
                if (m == 1) chk(32'(lane_symbol[0]), 32'(s[6] ^ s[5]));
            end else begin
                chk(32'(lane_symbol), 32'(syms[m]));
            end
            if (m == 6 || m == 7) chk(32'(lane_is_k), 32'(m == 7));
        end
        set_mode(`IDX_TEST_PATTERN_SELECT, 32'h0);
        for (int f = 0; f < 4; f++) begin
            set_mode(`IDX_FRAME_END_CHAR_SELECT, 32'(f));
            frame_end_ok <= 1'b1;
            @(posedge clk);
            frame_end_ok <= 1'b0;
            #1;
            chk({23'h0, lane_is_k, lane_symbol}, {23'h0, 1'b1, commas[f]});
        end
        // status flags, masking and the shared interrupt
        set_mode(`IDX_TEST_PATTERN_SELECT, 32'h7);
        pll_locked_pin <= 1'b1;
        repeat (10) @(posedge clk);
        bus(1'b1, `IDX_IRQ_MASK, 32'h18, 1'b0);
        bus(1'b0, `IDX_LINK_STATUS_WORD, 32'h0, 1'b0);
        chk(rd, 32'h64);
        sysref_pulse();
        bus(1'b0, `IDX_LINK_STATUS_WORD, 32'h0, 1'b0);
        chk(rd, 32'h6c);
        chk(32'(irq), 32'h1);
        bus(1'b1, `IDX_LINK_STATUS_WORD, 32'h08, 1'b0);
        sysref_pulse();
        bus(1'b0, `IDX_LINK_STATUS_WORD, 32'h0, 1'b0);
        chk(rd, 32'h64);
        chk(32'(irq), 32'h0);
        bus(1'b1, `IDX_IRQ_MASK, 32'h00, 1'b0);
        bus(1'b1, `IDX_LINK_STATUS_WORD, 32'h10, 1'b1);
        bus(1'b0, `IDX_LINK_STATUS_WORD, 32'h0, 1'b0);
        chk(rd, 32'h74);
        chk(32'(irq), 32'h0);
        bus(1'b1, `IDX_IRQ_MASK, 32'h10, 1'b0);
        @(posedge clk);
        #1;
        chk(32'(irq), 32'h1);
        bus(1'b1, `IDX_LINK_STATUS_WORD, 32'h10, 1'b0);
        bus(1'b1, `IDX_LINK_BLOCK_ENABLE, 32'h0, 1'b0);
        // receiver drops its request a cycle late, then two sync stages
        repeat (6) @(posedge clk);
        bus(1'b0, `IDX_LINK_STATUS_WORD, 32'h0, 1'b0);
        chk(rd, 32'h04);
        chk(32'({irq, serializer_power_down}), 32'h1);
        // reset in mid-run brings the identifier back
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, `IDX_LINK_IDENTIFIER, 32'h0, 1'b0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
endmodule : tb_serial_link_test_and_status_regs
